// ### core/timer_defines.svh
// Purpose: named constants of the triple down-counter timer
// Assumes: included by bare name wherever a constant is needed
// Notes:   control word keeps the conventional field order
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Synchronised pin bundle; ticks idle low so reset makes no false tick edge
`define SYNC_W      19
`define SYNC_RST    19'h7FFC7
`define LINE_IDLE   1'b1

// Port codes on the select pins
`define PORT_CNT0   2'h0
`define PORT_CNT1   2'h1
`define PORT_CTRL   2'h3

// Control word fields
`define CW_SEL      7:6
`define CW_ACC      5:4
`define CW_FN       3:1
`define CW_BCD      0
`define CW_LOW6     5:0
`define SEL_MULTI   2'h3

// Access order codes
`define ACC_LATCH   2'h0
`define ACC_LOW     2'h1
`define ACC_HIGH    2'h2
`define ACC_BOTH    2'h3

// Multiple latch command bits, both flags active low
`define ML_CNT_N    5
`define ML_STS_N    4
`define ML_CH_LO    1

// Counting functions
`define MODE_0      3'h0
`define MODE_1      3'h1
`define MODE_2      3'h2
`define MODE_3      3'h3
`define MODE_4      3'h4
`define MODE_5      3'h5

// Count values and byte lanes
`define LO_BYTE     7:0
`define HI_BYTE     15:8
`define BYTE_ZERO   8'h00
`define CNT_ZERO    16'h0000
`define CNT_ONE     16'h0001
`define CNT_TWO     16'h0002
`define BCD_DIGITS  4
`define BCD_W       4
`define DIGIT_NINE  4'h9
`define DIGIT_ONE   4'h1
`define DIGIT_ZERO  4'h0

`endif

// ### core/timer_pkg.sv
// Purpose: types shared by the timer modules
// Assumes: timer_defines.svh supplies the widths
// Notes:   all state lives in packed structs
`include "timer_defines.svh"
package timer_pkg;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_WAIT = 2'b01,
      PH_RUN  = 2'b11,
      PH_DONE = 2'b10
   } phase_t;

   typedef struct packed {
      logic [5:0]  ctrl;
      logic [15:0] countReg;
      logic [15:0] down;
      logic [15:0] latchVal;
      logic [7:0]  statLatch;
      logic        latched;
      logic        statLatched;
      logic        wrHiNext;
      logic        rdHiNext;
      logic        out;
      logic        nullCnt;
      logic        trig;
      logic        gatePrev;
      logic        tickPrev;
      phase_t      phase;
   } chan_t;

   typedef struct packed {
      chan_t [2:0] ch;
      logic [7:0]  busOut;
      logic        busOeN;
      logic        wrPrev;
      logic        rdPrev;
   } core_t;

   typedef struct packed {
      logic [`SYNC_W-1:0] first;
      logic [`SYNC_W-1:0] second;
   } sync_t;

endpackage

// ### core/pin_sync_if.sv
// Purpose: synchronised pin levels from the synchroniser to the core
// Assumes: one clock domain
// Notes:   active-low strobes keep their polarity
`timescale 1ns/100ps
interface pin_sync_if;
   logic       chipSelN;
   logic       readN;
   logic       writeN;
   logic [1:0] portSel;
   logic [7:0] busIn;
   logic [2:0] tick;
   logic [2:0] permit;

   modport syncSide (output chipSelN, readN, writeN, portSel, busIn, tick, permit);
   modport coreSide (input  chipSelN, readN, writeN, portSel, busIn, tick, permit);
endinterface

// ### core/pin_sync.sv
// Purpose: two-stage synchroniser for every pin input
// Assumes: pins are asynchronous to clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`include "timer_defines.svh"
module pin_sync
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst_n,
   // Raw pins and synchronised view
   input  wire logic [`SYNC_W-1:0] rawPins,
   pin_sync_if.syncSide            syncd
);

   sync_t s_q;
   sync_t s_d;

   always_comb begin
      s_d.first  = rawPins;
      s_d.second = s_q.first;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q.first  <= `SYNC_RST;
         s_q.second <= `SYNC_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign {syncd.chipSelN, syncd.readN, syncd.writeN, syncd.portSel,
           syncd.busIn, syncd.tick, syncd.permit} = s_q.second;

endmodule

// ### core/triple_timer.sv
// Purpose: three 16-bit down counters behind an 8-bit strobed host port
// Assumes: 125 MHz clock, all pins asynchronous and synchronised first
// Notes:   counters step on the falling edge of their tick input
//
// Summary of operation
// (R1) Drive data bus only while chip selected
// (R2) Host selects chip for every access
// (R3) Low strobe means read or write
// (R4) Port codes pick counter zero, one, two, control
// (R5) Data taken at write strobe rising edge
// (R6) Control register is write only
// (R7) Down counter runs binary or decimal
// (R8) Count register bytewise, moved whole
// (R9) Single byte write zeroes other byte
// (R10) Counting starts after the move
// (R11) Count latch follows the down counter
// (R12) Latch command freezes value until read
// (R13) Mode write copies low six bits
// (R14) Status top bits show pin, null
// (R15) Multiple latch captures status until read
// (R16) Gate inhibits or triggers by mode
// (R17) Result pin usable as interrupt request
// (R18) Bit seven pin state, six null
// (R19) Null set on writes, cleared on move
// (R20) Range FFFF binary, 9999 decimal
// (R21) Unread latch ignores further latch commands
// (R22) Six counting modes, zero to five
`timescale 1ns/100ps
`include "timer_defines.svh"
module triple_timer
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Host port
   input  wire logic       chipSelN,
   input  wire logic       readN,
   input  wire logic       writeN,
   input  wire logic [1:0] portSelect,
   input  wire logic [7:0] hostBusIn,
   output logic      [7:0] hostBusOut,
   output logic            hostBusOeN,
   // Counter pins
   input  wire logic [2:0] countTick,
   input  wire logic [2:0] countPermitPin,
   output logic      [2:0] timerResultPin
);

   pin_sync_if syncd ();

   core_t      st_q;
   core_t      st_d;
   logic       wrEvt;
   logic       rdEvt;
   logic [1:0] port;
   logic [7:0] din;

   pin_sync u_sync (
      .clock   (clock),
      .rst_n   (rst_n),
      .rawPins ({chipSelN, readN, writeN, portSelect, hostBusIn,
                 countTick, countPermitPin}),
      .syncd   (syncd)
   );

   assign port = syncd.portSel;
   assign din  = syncd.busIn;

   // Strobe ends only count while selected
   assign wrEvt = syncd.writeN && !st_q.wrPrev && !syncd.chipSelN; // R2 R3 R5
   assign rdEvt = syncd.readN && !st_q.rdPrev && !syncd.chipSelN; // R2 R3

   // One step down; zero wraps to the top of the range
   function automatic logic [15:0] decOne(input logic [15:0] v, input logic bcd);
      logic [15:0] r;
      logic        borrow;
      r      = v;
      borrow = 1'b1;
      if (!bcd) begin
         r = v - `CNT_ONE; // R7 R20
      end else begin
         for (int k = 0; k < `BCD_DIGITS; k++) begin
            if (borrow) begin
               if (r[k*`BCD_W +: `BCD_W] == `DIGIT_ZERO) begin
                  r[k*`BCD_W +: `BCD_W] = `DIGIT_NINE; // R7 R20
               end else begin
                  r[k*`BCD_W +: `BCD_W] = r[k*`BCD_W +: `BCD_W] - `DIGIT_ONE;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // Functions six and seven alias two and three
   function automatic logic [2:0] effMode(input logic [2:0] fn);
      return fn[1] ? {1'b0, fn[1:0]} : fn;
   endfunction

   function automatic logic [7:0] statusOf(input chan_t c);
      return {c.out, c.nullCnt, c.ctrl}; // R14 R18
   endfunction

   function automatic chan_t loadCount(input chan_t c);
      chan_t r;
      r         = c;
      r.down    = c.countReg; // R8 R10
      r.nullCnt = 1'b0; // R19
      r.trig    = 1'b0;
      return r;
   endfunction

   always_comb begin
      chan_t       c;
      logic [2:0]  m;
      logic [15:0] v;
      logic        done;
      logic        tickRise;
      logic        tickFall;
      logic        en;
      c        = '0;
      m        = `MODE_0;
      v        = `CNT_ZERO;
      done     = 1'b0;
      tickRise = 1'b0;
      tickFall = 1'b0;
      en       = 1'b0;
      st_d        = st_q;
      st_d.wrPrev = syncd.writeN;
      st_d.rdPrev = syncd.readN;
      // Control port reads float the bus rather than leak the command
      st_d.busOeN = syncd.chipSelN || syncd.readN || (port == `PORT_CTRL); // R1 R3 R6
      for (int i = 0; i < 3; i++) begin
         c = st_q.ch[i];
         m = effMode(c.ctrl[`CW_FN]);
         if (!c.latched) begin
            c.latchVal = c.down; // R11
         end

         // Read data: pending status goes out before the count
         if (port == 2'(i)) begin // R4
            v = st_q.ch[i].latchVal;
            if (c.statLatched) begin
               st_d.busOut = c.statLatch; // R15
            end else begin
               case (c.ctrl[`CW_ACC])
                  `ACC_HIGH: st_d.busOut = v[`HI_BYTE];
                  `ACC_BOTH: st_d.busOut = c.rdHiNext ? v[`HI_BYTE] : v[`LO_BYTE];
                  default:   st_d.busOut = v[`LO_BYTE];
               endcase
            end
         end
         if (rdEvt && port == 2'(i)) begin
            if (c.statLatched) begin
               c.statLatched = 1'b0; // R15
            end else if (c.ctrl[`CW_ACC] == `ACC_BOTH && !c.rdHiNext) begin
               c.rdHiNext = 1'b1;
            end else begin
               c.rdHiNext = 1'b0;
               c.latched  = 1'b0; // R12
            end
         end

         // Count write
         if (wrEvt && port == 2'(i)) begin // R4 R5
            done = 1'b1;
            case (c.ctrl[`CW_ACC])
               `ACC_LOW:  c.countReg = {`BYTE_ZERO, din}; // R9
               `ACC_HIGH: c.countReg = {din, `BYTE_ZERO}; // R9
               default: begin
                  if (!c.wrHiNext) begin
                     c.countReg[`LO_BYTE] = din; // R8
                     c.wrHiNext = 1'b1;
                     done = 1'b0;
                  end else begin
                     c.countReg[`HI_BYTE] = din; // R8
                     c.wrHiNext = 1'b0;
                  end
               end
            endcase
            if (done) begin
               c.nullCnt = 1'b1; // R19
               if (m == `MODE_0) begin
                  c.out = 1'b0;
               end
               // Rate modes pick the new count up at their next reload
               if (c.phase == PH_IDLE || !m[1]) begin
                  c.phase = PH_WAIT;
               end
            end
         end

         // Control write
         if (wrEvt && port == `PORT_CTRL) begin // R4 R6
            if (din[`CW_SEL] == `SEL_MULTI) begin
               if (din[`ML_CH_LO + i]) begin
                  if (!din[`ML_CNT_N] && !c.latched) begin
                     c.latched = 1'b1; // R21
                  end
                  if (!din[`ML_STS_N] && !c.statLatched) begin
                     c.statLatch   = statusOf(st_q.ch[i]); // R15
                     c.statLatched = 1'b1;
                  end
               end
            end else if (din[`CW_SEL] == 2'(i)) begin
               if (din[`CW_ACC] == `ACC_LATCH) begin
                  if (!c.latched) begin
                     c.latched = 1'b1; // R12 R21
                  end
               end else begin
                  c.ctrl        = din[`CW_LOW6]; // R13
                  c.nullCnt     = 1'b1; // R19
                  c.phase       = PH_IDLE;
                  c.out         = (effMode(din[`CW_FN]) != `MODE_0);
                  c.wrHiNext    = 1'b0;
                  c.rdHiNext    = 1'b0;
                  c.latched     = 1'b0;
                  c.statLatched = 1'b0;
                  c.trig        = 1'b0;
               end
            end
         end

         // Gate edge sampled on the tick rise, gate level and stepping taken on the tick fall
         m        = effMode(c.ctrl[`CW_FN]);
         tickRise = syncd.tick[i] && !c.tickPrev;
         tickFall = !syncd.tick[i] && c.tickPrev;
         c.tickPrev = syncd.tick[i];
         if (tickRise) begin
            if (syncd.permit[i] && !c.gatePrev) begin
               c.trig = 1'b1; // R16
            end
            c.gatePrev = syncd.permit[i];
         end
         // Triggered modes ignore the gate level
         en = syncd.permit[i] || (m[0] && !m[1]); // R16
         if (m[1] && !syncd.permit[i]) begin
            c.out = 1'b1; // R16
         end
         if (tickFall) begin
            case (c.phase)
               PH_WAIT: begin
                  if (!(m[0] && !m[1]) || c.trig) begin
                     c       = loadCount(c); // R8 R10
                     c.phase = PH_RUN;
                     if (m == `MODE_1) begin
                        c.out = 1'b0;
                     end
                  end
               end
               PH_RUN: begin
                  if (c.trig && m != `MODE_0 && m != `MODE_4) begin
                     c = loadCount(c); // R16
                     if (m == `MODE_1) begin
                        c.out = 1'b0;
                     end
                  end else if (en) begin
                     case (m) // R22
                        `MODE_2: begin
                           if (c.down == `CNT_ONE) begin
                              c     = loadCount(c);
                              c.out = 1'b1;
                           end else begin
                              c.down = decOne(c.down, c.ctrl[`CW_BCD]);
                              if (c.down == `CNT_ONE) begin
                                 c.out = 1'b0;
                              end
                           end
                        end
                        `MODE_3: begin
                           if (c.down == `CNT_TWO || c.down == `CNT_ONE) begin
                              c     = loadCount(c);
                              c.out = !c.out;
                           end else begin
                              c.down = decOne(decOne(c.down, c.ctrl[`CW_BCD]),
                                              c.ctrl[`CW_BCD]);
                           end
                        end
                        `MODE_4, `MODE_5: begin
                           c.down = decOne(c.down, c.ctrl[`CW_BCD]);
                           if (c.down == `CNT_ZERO) begin
                              c.out   = 1'b0;
                              c.phase = PH_DONE;
                           end
                        end
                        default: begin
                           c.down = decOne(c.down, c.ctrl[`CW_BCD]);
                           if (c.down == `CNT_ZERO) begin
                              c.out = 1'b1;
                           end
                        end
                     endcase
                  end
               end
               PH_DONE: begin
                  // Strobe lasts one tick; only a gate trigger restarts mode 5, mode 4 waits for a new count
                  c.out = 1'b1;
                  if (c.trig && m == `MODE_5) begin
                     c       = loadCount(c);
                     c.phase = PH_RUN;
                  end
               end
               default: begin
                  c.phase = PH_IDLE;
               end
            endcase
         end
         st_d.ch[i] = c;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q        <= '0;
         st_q.busOeN <= `LINE_IDLE;
         st_q.wrPrev <= `LINE_IDLE;
         st_q.rdPrev <= `LINE_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign hostBusOut     = st_q.busOut;
   assign hostBusOeN     = st_q.busOeN; // R1
   assign timerResultPin = {st_q.ch[2].out, st_q.ch[1].out, st_q.ch[0].out}; // R17

   busFloat_a: assert property (@(posedge clock) disable iff (!rst_n) // R1
      syncd.chipSelN |=> hostBusOeN)
      else $error("data bus driven while deselected");

   readOnly_a: assert property (@(posedge clock) disable iff (!rst_n) // R3
      !hostBusOeN |-> !$past(syncd.readN))
      else $error("data bus driven without a read strobe");

   ctrlHidden_a: assert property (@(posedge clock) disable iff (!rst_n) // R6
      port == `PORT_CTRL |=> hostBusOeN)
      else $error("control port read drove the bus");

   byteZero_a: assert property (@(posedge clock) disable iff (!rst_n) // R9
      wrEvt && port == `PORT_CNT1 && st_q.ch[1].ctrl[`CW_ACC] == `ACC_LOW
      |=> st_q.ch[1].countReg == {`BYTE_ZERO, $past(din)})
      else $error("single byte count write wrong");

   modeCopy_a: assert property (@(posedge clock) disable iff (!rst_n) // R13
      wrEvt && port == `PORT_CTRL && din[`CW_SEL] == `PORT_CNT0
      && din[`CW_ACC] != `ACC_LATCH
      |=> st_q.ch[0].ctrl == $past(din[`CW_LOW6]) && st_q.ch[0].nullCnt)
      else $error("mode write not copied to status");

   countMove_a: assert property (@(posedge clock) disable iff (!rst_n) // R8
      $past(st_q.ch[0].phase) == PH_WAIT && st_q.ch[0].phase == PH_RUN
      |-> st_q.ch[0].down == st_q.ch[0].countReg && !st_q.ch[0].nullCnt)
      else $error("count transfer wrong");

   latchFollow_a: assert property (@(posedge clock) disable iff (!rst_n) // R11
      !$past(st_q.ch[0].latched) |-> st_q.ch[0].latchVal == $past(st_q.ch[0].down))
      else $error("count latch not following");

   latchHold_a: assert property (@(posedge clock) disable iff (!rst_n) // R12
      st_q.ch[0].latched && !(rdEvt && port == `PORT_CNT0)
      |=> $stable(st_q.ch[0].latchVal))
      else $error("latched count changed before read");

   statusCap_a: assert property (@(posedge clock) disable iff (!rst_n) // R15
      wrEvt && port == `PORT_CTRL && din[`CW_SEL] == `SEL_MULTI
      && din[`ML_CH_LO] && !din[`ML_STS_N] && !st_q.ch[0].statLatched
      |=> st_q.ch[0].statLatched
      && st_q.ch[0].statLatch == {$past(st_q.ch[0].out), $past(st_q.ch[0].nullCnt),
                                  $past(st_q.ch[0].ctrl)})
      else $error("status latch capture wrong");

endmodule

// ### bench/host_model.sv
// Purpose: processor side of the strobed timer port
// Assumes: every request starts 1 ns after a rising clock edge
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/100ps
module host_model (
   // Clock
   input  wire logic       clock,
   // Strobed port
   output logic            chipSelN,
   output logic            readN,
   output logic            writeN,
   output logic      [1:0] portSelect,
   output logic      [7:0] hostBusIn,
   input  wire logic [7:0] hostBusOut,
   input  wire logic       hostBusOeN,
   // Read results
   output logic            rdValid,
   output logic      [8:0] rdWord
);
   initial begin
      chipSelN   = 1'b1;
      readN      = 1'b1;
      writeN     = 1'b1;
      portSelect = 2'h0;
      hostBusIn  = 8'h00;
      rdValid    = 1'b0;
      rdWord     = 9'h000;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic [1:0] port, input logic [7:0] data);
      step(1);
      chipSelN   = 1'b0;
      portSelect = port;
      hostBusIn  = data;
      writeN     = 1'b0;
      step(4);
      writeN = 1'b1;
      // Port and data held past the synchroniser lag
      step(3);
      chipSelN  = 1'b1;
      hostBusIn = ~data;
      step(2);
   endtask

   // Top bit of the word tells whether the device drove the bus
   task automatic rd(input logic [1:0] port, input logic sel);
      logic       got;
      logic [7:0] data;
      got        = 1'b0;
      data       = 8'h00;
      step(1);
      chipSelN   = ~sel;
      portSelect = port;
      readN      = 1'b0;
      repeat (6) begin
         step(1);
         if (!got && hostBusOeN === 1'b0) begin
            got  = 1'b1;
            data = hostBusOut;
         end
      end
      readN = 1'b1;
      step(4);
      chipSelN = 1'b1;
      rdWord   = {got, data};
      rdValid  = 1'b1;
      step(1);
      rdValid  = 1'b0;
   endtask
endmodule

// ### bench/tb_triple_counter_host_interface.sv
// Purpose: self-checking bench for the triple down-counter timer
// Assumes: host model launches strobes, bench drives ticks and gates
// Notes:   reads are checked in order against a queue of expected bytes
`timescale 1ns/100ps
module tb_triple_counter_host_interface;
   logic        clock;
   logic        rst_n;
   logic        chipSelN;
   logic        readN;
   logic        writeN;
   logic [1:0]  portSelect;
   logic [7:0]  hostBusIn;
   logic [7:0]  hostBusOut;
   logic        hostBusOeN;
   logic [2:0]  countTick;
   logic [2:0]  countPermitPin;
   logic [2:0]  timerResultPin;
   logic        rdValid;
   logic [8:0]  rdWord;
   logic [8:0]  expQ[$];
   logic [15:0] cnt;
   logic [7:0]  ctl;
   int          n_mismatch;
   int          checks;
   int          seed;

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   triple_timer u_dut (
      .clock          (clock),
      .rst_n          (rst_n),
      .chipSelN       (chipSelN),
      .readN          (readN),
      .writeN         (writeN),
      .portSelect     (portSelect),
      .hostBusIn      (hostBusIn),
      .hostBusOut     (hostBusOut),
      .hostBusOeN     (hostBusOeN),
      .countTick      (countTick),
      .countPermitPin (countPermitPin),
      .timerResultPin (timerResultPin)
   );

   host_model u_host (
      .clock      (clock),
      .chipSelN   (chipSelN),
      .readN      (readN),
      .writeN     (writeN),
      .portSelect (portSelect),
      .hostBusIn  (hostBusIn),
      .hostBusOut (hostBusOut),
      .hostBusOeN (hostBusOeN),
      .rdValid    (rdValid),
      .rdWord     (rdWord)
   );

   task automatic compareByte(input logic [8:0] got, input logic [8:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic compareBit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t pin %b expected %b", $time, got, exp);
      end
   endtask

   task automatic rdExp(input logic [1:0] port, input logic [8:0] exp);
      expQ.push_back(exp);
      u_host.rd(port, 1'b1);
   endtask

   // Tick high and low four cycles each, output settled after the fall
   task automatic tick(input int ch, input int n);
      repeat (n) begin
         u_host.step(1);
         countTick[ch] = 1'b1;
         u_host.step(4);
         countTick[ch] = 1'b0;
         u_host.step(3);
      end
   endtask

   task automatic summarize;
      $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clock) begin
      if (rdValid === 1'b1) begin
         if (expQ.size() > 0)
            compareByte(rdWord, expQ.pop_front());
         else
            compareByte(rdWord, 9'hXXX);
      end
   end

   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      summarize();
   end

   initial begin
      seed           = 29;
      n_mismatch     = 0;
      checks         = 0;
      rst_n          = 1'b0;
      countTick      = 3'h0;
      countPermitPin = 3'h7;
      u_host.step(3);
      rst_n = 1'b1;
      compareBit(hostBusOeN, 1'b1);
      // Each counting function leaves its code in the status byte
      for (int m = 0; m < 6; m++) begin
         ctl = 8'hB0 | 8'(m << 1);
         // Random gate: no ticks run, and rate modes read high anyway
         countPermitPin[2] = 1'($random(seed));
         u_host.wr(2'h3, ctl);
         u_host.wr(2'h3, 8'hE8);
         rdExp(2'h2, {1'b1, (m != 0), 1'b1, ctl[5:0]});
      end
      countPermitPin[2] = 1'b1;
      // Random binary count, top bit set so no terminal count is met
      cnt = 16'($random(seed)) | 16'h8000;
      u_host.wr(2'h3, 8'h30);
      u_host.wr(2'h0, cnt[7:0]);
      u_host.wr(2'h0, cnt[15:8]);
      u_host.wr(2'h3, 8'hE2);
      rdExp(2'h0, 9'h170);
      tick(0, 1);
      u_host.wr(2'h3, 8'hC2);
      rdExp(2'h0, 9'h130);
      rdExp(2'h0, {1'b1, cnt[7:0]});
      rdExp(2'h0, {1'b1, cnt[15:8]});
      tick(0, 2);
      u_host.wr(2'h3, 8'h00);
      tick(0, 1);
      u_host.wr(2'h3, 8'h00);
      tick(0, 1);
      cnt = cnt - 16'h0002;
      rdExp(2'h0, {1'b1, cnt[7:0]});
      rdExp(2'h0, {1'b1, cnt[15:8]});
      cnt = cnt - 16'h0002;
      rdExp(2'h0, {1'b1, cnt[7:0]});
      rdExp(2'h0, {1'b1, cnt[15:8]});
      // Decimal borrow across every digit
      u_host.wr(2'h3, 8'h31);
      u_host.wr(2'h0, 8'h00);
      u_host.wr(2'h0, 8'h10);
      tick(0, 2);
      rdExp(2'h0, 9'h199);
      rdExp(2'h0, 9'h109);
      // Rate mode, count three: low on the last tick, gate low forces high
      u_host.wr(2'h3, 8'h14);
      u_host.wr(2'h0, 8'h03);
      tick(0, 3);
      compareBit(timerResultPin[0], 1'b0);
      tick(0, 1);
      compareBit(timerResultPin[0], 1'b1);
      tick(0, 2);
      countPermitPin[0] = 1'b0;
      u_host.step(4);
      compareBit(timerResultPin[0], 1'b1);
      countPermitPin[0] = 1'b1;
      // Stale high byte first, so a missing zero fill shows
      u_host.wr(2'h3, 8'h70);
      u_host.wr(2'h1, 8'hFF);
      u_host.wr(2'h1, 8'hFF);
      u_host.wr(2'h3, 8'h50);
      u_host.wr(2'h1, 8'h02);
      tick(1, 1);
      countPermitPin[1] = 1'b0;
      tick(1, 2);
      compareBit(timerResultPin[1], 1'b0);
      countPermitPin[1] = 1'b1;
      tick(1, 1);
      compareBit(timerResultPin[1], 1'b0);
      tick(1, 1);
      compareBit(timerResultPin[1], 1'b1);
      u_host.wr(2'h3, 8'hA0);
      u_host.wr(2'h2, 8'hCD);
      tick(2, 2);
      rdExp(2'h2, 9'h1CC);
      compareBit(timerResultPin[2], 1'b0);
      // Control port and deselected reads leave the bus floating
      rdExp(2'h3, 9'h000);
      expQ.push_back(9'h000);
      u_host.rd(2'h0, 1'b0);
      u_host.step(4);
      compareBit(hostBusOeN, 1'b1);
      summarize();
   end
endmodule
